//--- inc/ncl_params.svh
`ifndef NCL_PARAMS_SVH
`define NCL_PARAMS_SVH

// persistent word field positions
`define NCL_DUMMY_HI 15
`define NCL_DUMMY_LO 12
`define NCL_EXEC_HI 11
`define NCL_EXEC_LO 9
`define NCL_DTR_BIT 5
`define NCL_HOLD_BIT 4
`define NCL_QUAD_BIT 3
`define NCL_DUAL_BIT 2
`define NCL_SEG_BIT 1
`define NCL_ADDR_BIT 0
// erased / factory value of the persistent word
`define NCL_WORD_RESET 16'hFFFF
// volatile word field positions
`define NCL_VDUMMY_HI 7
`define NCL_VDUMMY_LO 4
`define NCL_VEXEC_BIT 3
// dummy codes meaning per-command default; execute-in-place off code and highest valid code
`define NCL_DUMMY_DEF0 4'h0
`define NCL_DUMMY_DEF1 4'hF
`define NCL_EXEC_OFF 3'h7
`define NCL_EXEC_MAX 3'h4
// flag status ready bit
`define NCL_FLAG_READY_BIT 7
// persistent program time and clock period in ns
`define NCL_PROG_TIME_NS 200000
`define NCL_CLK_NS 8

`endif

//--- inc/ncl_pkg.sv
package ncl_pkg;

	typedef enum logic [2:0] {
		NCL_EXEC_FAST = 3'h0,
		NCL_EXEC_DUAL_OUT = 3'h1,
		NCL_EXEC_DUAL_IO = 3'h2,
		NCL_EXEC_QUAD_OUT = 3'h3,
		NCL_EXEC_QUAD_IO = 3'h4,
		NCL_EXEC_DISABLED = 3'h7
	} ncl_exec_t;

	typedef enum logic [1:0] {
		NCL_PROTO_EXT = 2'h0,
		NCL_PROTO_DUAL = 2'h1,
		NCL_PROTO_QUAD = 2'h2
	} ncl_proto_t;

	// decoded operating configuration
	typedef struct packed {
		logic [3:0] dummy_cycles;
		logic dummy_default;
		logic exec_enable;
		ncl_exec_t exec_mode;
		logic dtr_enable;
		logic hold_reset_enable;
		ncl_proto_t protocol;
		logic high_segment;
		logic four_byte_addr;
	} ncl_cfg_t;

	typedef enum logic [3:0] {
		NCL_ST_LOAD = 4'h1,
		NCL_ST_IDLE = 4'h2,
		NCL_ST_PROG = 4'h4,
		NCL_ST_DONE = 4'h8
	} ncl_state_t;

endpackage : ncl_pkg

//--- logic/ncl_decode.sv
`timescale 1ns/1ps
`include "ncl_params.svh"

module ncl_decode (
	input wire logic [15:0] word,
	output ncl_pkg::ncl_cfg_t cfg
);
	logic [3:0] dummy;
	logic [2:0] exec_code;

	assign dummy = word[`NCL_DUMMY_HI:`NCL_DUMMY_LO];
	assign exec_code = word[`NCL_EXEC_HI:`NCL_EXEC_LO];

	always_comb begin
		cfg = '0;
		cfg.dummy_cycles = dummy;
		cfg.dummy_default = (dummy == `NCL_DUMMY_DEF0) || (dummy == `NCL_DUMMY_DEF1);
		cfg.exec_enable = (exec_code <= `NCL_EXEC_MAX);
		cfg.exec_mode = (exec_code <= `NCL_EXEC_MAX) ? ncl_pkg::ncl_exec_t'(exec_code) :
			ncl_pkg::NCL_EXEC_DISABLED;
		cfg.dtr_enable = ~word[`NCL_DTR_BIT];
		cfg.hold_reset_enable = word[`NCL_HOLD_BIT];
		if (!word[`NCL_QUAD_BIT]) begin
			cfg.protocol = ncl_pkg::NCL_PROTO_QUAD;
		end else if (!word[`NCL_DUAL_BIT]) begin
			cfg.protocol = ncl_pkg::NCL_PROTO_DUAL;
		end else begin
			cfg.protocol = ncl_pkg::NCL_PROTO_EXT;
		end
		cfg.high_segment = ~word[`NCL_SEG_BIT];
		cfg.four_byte_addr = ~word[`NCL_ADDR_BIT];
	end

endmodule : ncl_decode

//--- logic/ncl_loader.sv
`timescale 1ns/1ps
`include "ncl_params.svh"

module ncl_loader #(
	parameter int PROG_CYCLES = (`NCL_PROG_TIME_NS + `NCL_CLK_NS - 1) / `NCL_CLK_NS
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic cmd_read_word,
	input wire logic cmd_write_word,
	input wire logic [15:0] cmd_wdata,
	input wire logic cmd_write_volatile,
	input wire logic [7:0] cmd_vdata,
	output logic [15:0] rdata,
	output logic rdata_valid,
	output logic [7:0] flag_status,
	output logic load_done,
	output ncl_pkg::ncl_cfg_t active_cfg
);
	// ----------------------------------------
	// persistent storage
	// ----------------------------------------
	// models the cell array: changed only by programming, never by reset
	logic [15:0] persistent_config_word_reg = `NCL_WORD_RESET;
	logic [15:0] pending_reg;
	ncl_pkg::ncl_state_t state_reg;
	logic [31:0] count_reg;
	ncl_pkg::ncl_cfg_t stored_cfg;

	ncl_decode u_decode (
		.word(persistent_config_word_reg),
		.cfg(stored_cfg)
	);

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_reg <= ncl_pkg::NCL_ST_LOAD;
			count_reg <= '0;
		end else begin
			case (state_reg)
				ncl_pkg::NCL_ST_LOAD: state_reg <= ncl_pkg::NCL_ST_IDLE;
				ncl_pkg::NCL_ST_IDLE: begin
					if (cmd_write_word) begin
						state_reg <= ncl_pkg::NCL_ST_PROG;
						count_reg <= '0;
					end
				end
				ncl_pkg::NCL_ST_PROG: begin
					if (count_reg == 32'(PROG_CYCLES - 1)) begin
						state_reg <= ncl_pkg::NCL_ST_DONE;
					end else begin
						count_reg <= count_reg + 32'h1;
					end
				end
				ncl_pkg::NCL_ST_DONE: state_reg <= ncl_pkg::NCL_ST_IDLE;
				default: state_reg <= ncl_pkg::NCL_ST_LOAD;
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pending_reg <= `NCL_WORD_RESET;
		end else if (state_reg == ncl_pkg::NCL_ST_IDLE && cmd_write_word) begin
			pending_reg <= cmd_wdata;
		end
	end

	// stored value survives reset, acts only on reload
	always_ff @(posedge clk) begin
		if (state_reg == ncl_pkg::NCL_ST_DONE) begin
			persistent_config_word_reg <= pending_reg;
		end
	end

	// ----------------------------------------
	// internal configuration
	// ----------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			active_cfg <= '0;
			load_done <= 1'b0;
		end else if (state_reg == ncl_pkg::NCL_ST_LOAD) begin
			active_cfg <= stored_cfg;
			load_done <= 1'b1;
		end else if (cmd_write_volatile) begin
			active_cfg.dummy_cycles <= cmd_vdata[`NCL_VDUMMY_HI:`NCL_VDUMMY_LO];
			active_cfg.dummy_default <=
				(cmd_vdata[`NCL_VDUMMY_HI:`NCL_VDUMMY_LO] == `NCL_DUMMY_DEF0) ||
				(cmd_vdata[`NCL_VDUMMY_HI:`NCL_VDUMMY_LO] == `NCL_DUMMY_DEF1);
			active_cfg.exec_enable <= ~cmd_vdata[`NCL_VEXEC_BIT];
		end
	end

	// ----------------------------------------
	// read answer and flag status
	// ----------------------------------------
	// read returns stored word next cycle
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rdata <= 16'h0000;
			rdata_valid <= 1'b0;
		end else begin
			rdata_valid <= cmd_read_word;
			if (cmd_read_word) begin
				rdata <= persistent_config_word_reg;
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			flag_status <= 8'h00;
		end else begin
			flag_status <= 8'h00;
			flag_status[`NCL_FLAG_READY_BIT] <= (state_reg == ncl_pkg::NCL_ST_IDLE) &&
				!cmd_write_word;
			flag_status[0] <= active_cfg.four_byte_addr;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_write_start;
		state_reg == ncl_pkg::NCL_ST_IDLE && cmd_write_word;
	endsequence

	a_busy_during_prog: assert property (@(posedge clk) disable iff (reset)
		state_reg == ncl_pkg::NCL_ST_PROG |=> !flag_status[`NCL_FLAG_READY_BIT])
		else $error("ready flag set while programming");

	a_load_after_reset: assert property (@(posedge clk) disable iff (reset)
		state_reg == ncl_pkg::NCL_ST_LOAD |=> load_done && active_cfg == $past(stored_cfg))
		else $error("configuration not downloaded");

	a_read_answer: assert property (@(posedge clk) disable iff (reset)
		cmd_read_word |=> rdata_valid && rdata == $past(persistent_config_word_reg))
		else $error("read answer wrong");

	a_write_no_effect: assert property (@(posedge clk) disable iff (reset)
		s_write_start ##1 !cmd_write_volatile |=> $stable(active_cfg))
		else $error("write changed live configuration");

	a_quad_wins: assert property (@(posedge clk) disable iff (reset)
		!persistent_config_word_reg[`NCL_QUAD_BIT] |-> stored_cfg.protocol == ncl_pkg::NCL_PROTO_QUAD)
		else $error("quad not selected");

	a_dual_sel: assert property (@(posedge clk) disable iff (reset)
		persistent_config_word_reg[3:2] == 2'h2 |-> stored_cfg.protocol == ncl_pkg::NCL_PROTO_DUAL)
		else $error("dual not selected");

	a_dtr_sel: assert property (@(posedge clk) disable iff (reset)
		stored_cfg.dtr_enable != persistent_config_word_reg[`NCL_DTR_BIT])
		else $error("double rate decode wrong");

	a_volatile_apply: assert property (@(posedge clk) disable iff (reset)
		state_reg != ncl_pkg::NCL_ST_LOAD && cmd_write_volatile |=>
			active_cfg.dummy_cycles == $past(cmd_vdata[7:4]))
		else $error("volatile write not applied");

	a_exec_reserved: assert property (@(posedge clk) disable iff (reset)
		persistent_config_word_reg[11:9] > 3'h4 |-> !stored_cfg.exec_enable)
		else $error("reserved execute-in-place code enabled");

	a_prog_commit: assert property (@(posedge clk) disable iff (reset)
		state_reg == ncl_pkg::NCL_ST_DONE |=> persistent_config_word_reg == $past(pending_reg))
		else $error("written word not stored");

	// commit cycle is when the stored word moves under a live config
	sequence s_commit;
		state_reg == ncl_pkg::NCL_ST_DONE && !cmd_write_volatile;
	endsequence

	a_commit_keeps_cfg: assert property (@(posedge clk) disable iff (reset)
		s_commit |=> $stable(active_cfg))
		else $error("stored word changed live configuration");

	a_busy_on_write: assert property (@(posedge clk) disable iff (reset)
		s_write_start |=> !flag_status[`NCL_FLAG_READY_BIT])
		else $error("ready flag set after write accepted");

	a_ready_idle: assert property (@(posedge clk) disable iff (reset)
		state_reg == ncl_pkg::NCL_ST_IDLE && !cmd_write_word |=>
			flag_status[`NCL_FLAG_READY_BIT])
		else $error("ready flag low while idle");

	a_busy_refuses: assert property (@(posedge clk) disable iff (reset)
		state_reg != ncl_pkg::NCL_ST_IDLE |=> $stable(pending_reg))
		else $error("write taken while busy");

	a_read_pulse: assert property (@(posedge clk) disable iff (reset)
		!cmd_read_word |=> !rdata_valid)
		else $error("read valid without request");

	a_flag_addr: assert property (@(posedge clk) disable iff (reset)
		1'b1 |=> flag_status[0] == $past(active_cfg.four_byte_addr))
		else $error("address mode flag wrong");

	a_quad_over_dual: assert property (@(posedge clk) disable iff (reset)
		persistent_config_word_reg[`NCL_QUAD_BIT:`NCL_DUAL_BIT] == 2'h0 |->
			stored_cfg.protocol == ncl_pkg::NCL_PROTO_QUAD)
		else $error("quad did not win over dual");

	a_dummy_count: assert property (@(posedge clk) disable iff (reset)
		stored_cfg.dummy_cycles ==
			persistent_config_word_reg[`NCL_DUMMY_HI:`NCL_DUMMY_LO])
		else $error("dummy count decode wrong");

	a_dummy_decode: assert property (@(posedge clk) disable iff (reset)
		stored_cfg.dummy_default == (stored_cfg.dummy_cycles == `NCL_DUMMY_DEF0 ||
			stored_cfg.dummy_cycles == `NCL_DUMMY_DEF1))
		else $error("dummy default decode wrong");

	a_hold_sel: assert property (@(posedge clk) disable iff (reset)
		stored_cfg.hold_reset_enable == persistent_config_word_reg[`NCL_HOLD_BIT])
		else $error("hold or reset function decode wrong");

	a_seg_sel: assert property (@(posedge clk) disable iff (reset)
		stored_cfg.high_segment != persistent_config_word_reg[`NCL_SEG_BIT])
		else $error("segment select decode wrong");

	a_addr_sel: assert property (@(posedge clk) disable iff (reset)
		stored_cfg.four_byte_addr != persistent_config_word_reg[`NCL_ADDR_BIT])
		else $error("address byte count decode wrong");

endmodule : ncl_loader

//--- dv/ncl_host_model.sv
`timescale 1ns/1ps
module ncl_host_model (
	input wire logic clk,
	output logic rd,
	output logic wr,
	output logic [15:0] wdata,
	output logic vwr,
	output logic [7:0] vdata
);
	initial begin
		rd = 1'b0;
		wr = 1'b0;
		vwr = 1'b0;
		wdata = 16'h0000;
		vdata = 8'h00;
	end
	task automatic send(input logic [1:0] kind, input logic [15:0] d);
		@(posedge clk);
		rd <= kind == 2'h0;
		wr <= kind == 2'h1;
		vwr <= kind == 2'h2;
		wdata <= d;
		vdata <= d[7:0];
		@(posedge clk);
		rd <= 1'b0;
		wr <= 1'b0;
		vwr <= 1'b0;
		// released bus shows inverse, not stale data
		wdata <= ~d;
		vdata <= ~d[7:0];
	endtask : send
endmodule : ncl_host_model

//--- dv/nonvolatile_config_loader_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("mismatch %s exp %h got %h", n, e, g); end end
module nonvolatile_config_loader_tb;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic rd, wr, vwr, rdata_valid, load_done;
	logic [15:0] wdata, rdata;
	logic [7:0] vdata, flag_status;
	ncl_pkg::ncl_cfg_t cfg;
	int n_mismatch = 0;
	int total_checks = 0;
	logic [15:0] words [8] = '{16'h0000, 16'h1237, 16'hE43B, 16'hF6FF,
		16'h5800, 16'h7A00, 16'h9C00, 16'hFFFF};
	always #4 clk = ~clk;
	ncl_loader #(.PROG_CYCLES(4)) dut_u (.clk(clk), .reset(reset),
		.cmd_read_word(rd), .cmd_write_word(wr), .cmd_wdata(wdata),
		.cmd_write_volatile(vwr), .cmd_vdata(vdata), .rdata(rdata),
		.rdata_valid(rdata_valid), .flag_status(flag_status),
		.load_done(load_done), .active_cfg(cfg));
	ncl_host_model host_u (.clk(clk), .rd(rd), .wr(wr), .wdata(wdata),
		.vwr(vwr), .vdata(vdata));
	// ----------------------------------------
	// scenario tasks
	// ----------------------------------------
	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test
	task automatic wait_ready();
		int i;
		for (i = 0; i < 60 && flag_status[7] !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		if (i == 60) begin
			n_mismatch++;
			finish_test();
		end
	endtask : wait_ready
	task automatic do_reset(input int n);
		@(posedge clk);
		reset <= 1'b1;
		repeat (n) @(posedge clk);
		`CHK("ld_rst", 1'b0, load_done)
		`CHK("flag_rst", 8'h00, flag_status)
		reset <= 1'b0;
		wait_ready();
		`CHK("load_done", 1'b1, load_done)
	endtask : do_reset
	task automatic check_cfg(input logic [15:0] w);
		logic [2:0] x;
		logic [3:0] d;
		ncl_pkg::ncl_proto_t p;
		x = w[11:9];
		d = w[15:12];
		p = ncl_pkg::NCL_PROTO_EXT;
		if (!w[2])
			p = ncl_pkg::NCL_PROTO_DUAL;
		// quad wins when both are low
		if (!w[3])
			p = ncl_pkg::NCL_PROTO_QUAD;
		`CHK("dflt", d == 4'h0 || d == 4'hF, cfg.dummy_default)
		if (d != 4'h0 && d != 4'hF)
			`CHK("dummy", d, cfg.dummy_cycles)
		`CHK("xen", x <= 3'h4, cfg.exec_enable)
		`CHK("xmode", x <= 3'h4 ? x : 3'h7, cfg.exec_mode)
		`CHK("dtr", ~w[5], cfg.dtr_enable)
		`CHK("hold", w[4], cfg.hold_reset_enable)
		`CHK("proto", p, cfg.protocol)
		`CHK("seg", ~w[1], cfg.high_segment)
		`CHK("four", ~w[0], cfg.four_byte_addr)
		`CHK("flag", {1'b1, 6'h00, ~w[0]}, flag_status)
	endtask : check_cfg
	task automatic read_check(input logic [15:0] e);
		host_u.send(2'h0, 16'h0000);
		#1;
		`CHK("valid", 1'b1, rdata_valid)
		`CHK("rdata", e, rdata)
		@(posedge clk);
		#1;
		`CHK("vpulse", 1'b0, rdata_valid)
	endtask : read_check
	task automatic write_word(input logic [15:0] w, input logic [15:0] old);
		host_u.send(2'h1, w);
		#1;
		`CHK("busy", 1'b0, flag_status[7])
		// write while busy must be ignored
		host_u.send(2'h1, ~w);
		wait_ready();
		check_cfg(old);
		read_check(w);
		do_reset(2);
		read_check(w);
		check_cfg(w);
	endtask : write_word
	task automatic vol_check();
		host_u.send(2'h2, 16'h0050);
		#1;
		`CHK("vdummy", 4'h5, cfg.dummy_cycles)
		`CHK("vexec", 1'b1, cfg.exec_enable)
		host_u.send(2'h2, 16'h00F8);
		#1;
		`CHK("vdflt", 1'b1, cfg.dummy_default)
		`CHK("vxoff", 1'b0, cfg.exec_enable)
		do_reset(2);
		check_cfg(16'hFFFF);
	endtask : vol_check
	initial begin
		do_reset(16);
		check_cfg(16'hFFFF);
		read_check(16'hFFFF);
		for (int i = 0; i < 8; i++)
			write_word(words[i], i > 0 ? words[i - 1] : 16'hFFFF);
		vol_check();
		finish_test();
	end
endmodule : nonvolatile_config_loader_tb
